/* hw/channel_select.sv */
// Per-channel transmit substitution: idle code or receive loopback
module channel_select
  import path_ctrl_pkg::*;
#(
  parameter int          CHANNELS  = 24,
  parameter logic [7:0]  IDLE_CODE = 8'h7f
) (
  // Controls
  input  wire logic                idle_register_function,
  input  wire logic [CHANNELS-1:0] transmit_idle_registers,
  input  wire logic [4:0]          channel_index,
  // Data
  input  wire logic [7:0]          tx_word,
  input  wire logic [7:0]          rx_word,
  output logic      [7:0]          out_word
);

  initial begin
    if (CHANNELS < 1 || CHANNELS > 32) $error("channel count unsupported");
  end

  logic flagged;

  always_comb begin
    flagged = 1'b0;
    if (32'(channel_index) < CHANNELS) begin
      flagged = transmit_idle_registers[channel_index];
    end
    if (!flagged) begin
      out_word = tx_word;
    end else if (idle_register_function) begin
      out_word = rx_word;
    end else begin
      out_word = IDLE_CODE;
    end
  end

endmodule

/* hw/dual_framer_path_control.sv */
// Path control registers and the routing they steer in the dual framer
module dual_framer_path_control
  import path_ctrl_pkg::*;
#(
  parameter int          CHANNELS  = 24,
  parameter logic [7:0]  IDLE_CODE = 8'h7f
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rst,
  // Parallel control port
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wdata,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [DATA_W-1:0]   rdata,
  output logic                     rd_valid,
  // Framer A line side pins
  input  wire logic                line_side_clock,
  input  wire logic                pattern_clock,
  input  wire logic                framer_a_nrz_in,
  input  wire logic                framer_a_sync_in,
  input  wire logic                line_rx_data,
  input  wire logic                framer_a_tx_data,
  input  wire logic                test_pattern_a,
  input  wire logic                pattern_data_in,
  output logic                     line_nrz_data_out,
  output logic                     line_frame_sync_out,
  output logic                     line_interface_tx_data,
  output logic                     framer_a_line_rx_data,
  output logic                     framer_a_tx_out,
  output logic                     pattern_data_sampled,
  // Framer A shared pins
  input  wire logic                rx_channel_clock_a,
  input  wire logic                rx_channel_block_a,
  input  wire logic                rx_link_clock_a,
  input  wire logic                rx_link_data_a,
  output logic                     shared_rx_clock_a,
  output logic                     shared_rx_data_a,
  // Framer B
  input  wire logic                framer_b_rx_clock_in,
  input  wire logic                framer_b_tx_clock,
  input  wire logic                framer_b_tx_data,
  input  wire logic                test_pattern_b,
  input  wire logic                rx_channel_clock_b,
  input  wire logic                rx_channel_block_b,
  input  wire logic                rx_link_clock_b,
  input  wire logic                rx_link_data_b,
  output logic                     framer_b_rx_clock,
  output logic                     framer_b_tx_clock_out,
  output logic                     framer_b_line_data,
  output logic                     framer_b_tx_out,
  output logic                     shared_rx_clock_b,
  output logic                     shared_rx_data_b,
  // Transmit channel substitution
  input  wire logic [CHANNELS-1:0] transmit_idle_registers_a,
  input  wire logic [CHANNELS-1:0] transmit_idle_registers_b,
  input  wire logic [4:0]          channel_index,
  input  wire logic [7:0]          tx_word_a,
  input  wire logic [7:0]          tx_word_b,
  input  wire logic [7:0]          framer_a_rx_serial_data,
  input  wire logic [7:0]          framer_b_rx_serial_data,
  output logic      [7:0]          tx_word_out_a,
  output logic      [7:0]          tx_word_out_b
);

  default clocking chk_cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  initial begin
    if (CHANNELS < 1 || CHANNELS > 32) $error("channel count unsupported");
  end

  function automatic logic [7:0] field_mask(input logic [7:0] a);
    field_mask = (a == FRAMER_A_PATH_CONTROL_ADDR) ? A_WRITE_MASK :
                 (a == FRAMER_B_PATH_CONTROL_ADDR) ? B_WRITE_MASK : 8'h00;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  localparam int NSYNC = 20;
  logic [NSYNC-1:0] pins_s;

  pin_sync #(.WIDTH(NSYNC)) u_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in ({line_side_clock, pattern_clock, framer_a_nrz_in,
                framer_a_sync_in, line_rx_data, framer_a_tx_data,
                test_pattern_a, pattern_data_in, rx_channel_clock_a,
                rx_channel_block_a, rx_link_clock_a, rx_link_data_a,
                framer_b_rx_clock_in, framer_b_tx_clock, framer_b_tx_data,
                test_pattern_b, rx_channel_clock_b, rx_channel_block_b,
                rx_link_clock_b, rx_link_data_b}),
    .sync_out (pins_s)
  );

  logic line_clk_s, pclk_s, nrz_s, sync_s, lrx_s, atx_s, tpa_s, pdi_s;
  logic rchclk_a_s, rchblk_a_s, rlclk_a_s, rlink_a_s;
  logic bclk_s, btxclk_s, btx_s, tpb_s;
  logic rchclk_b_s, rchblk_b_s, rlclk_b_s, rlink_b_s;

  assign {line_clk_s, pclk_s, nrz_s, sync_s, lrx_s, atx_s, tpa_s, pdi_s,
          rchclk_a_s, rchblk_a_s, rlclk_a_s, rlink_a_s,
          bclk_s, btxclk_s, btx_s, tpb_s,
          rchclk_b_s, rchblk_b_s, rlclk_b_s, rlink_b_s} = pins_s;

  //////////////////////////////////////////////////////////////////////////
  // Control port
  logic [7:0] ctrl_a_q;
  logic [7:0] ctrl_b_q;
  bus_state_t bus_q;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_a_q <= RESET_VALUE;
      ctrl_b_q <= RESET_VALUE;
    end else if (wr_en) begin
      // Unassigned bits are not stored; whatever the host writes there is masked off
      if (addr == FRAMER_A_PATH_CONTROL_ADDR) begin
        ctrl_a_q <= wdata & field_mask(addr);
      end
      if (addr == FRAMER_B_PATH_CONTROL_ADDR) begin
        ctrl_b_q <= wdata & field_mask(addr);
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_q    <= BUS_IDLE;
      rdata    <= '0;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      case (bus_q)
        BUS_IDLE, BUS_WRITE, BUS_READ: begin
          if (rd_en && !wr_en) begin
            bus_q    <= BUS_READ;
            rd_valid <= 1'b1;
            if (addr == FRAMER_A_PATH_CONTROL_ADDR) begin
              rdata <= ctrl_a_q;
            end else if (addr == FRAMER_B_PATH_CONTROL_ADDR) begin
              rdata <= ctrl_b_q;
            end else begin
              rdata <= '0;
            end
          end else if (wr_en) begin
            bus_q <= BUS_WRITE;
          end else begin
            bus_q <= BUS_IDLE;
          end
        end
        default: bus_q <= BUS_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Framer A line side
  logic a_lpol, a_ppol, a_test, a_alarm, a_liu_off, a_dlpm, a_func;
  assign a_lpol    = ctrl_a_q[A_LINE_CLOCK_POLARITY];
  assign a_ppol    = ctrl_a_q[A_PATTERN_CLOCK_POLARITY];
  assign a_test    = ctrl_a_q[A_TEST_MUX_ENABLE];
  assign a_alarm   = ctrl_a_q[A_NRZ_ALARM_FORCE];
  assign a_liu_off = ctrl_a_q[A_LINE_TO_FRAMER_A_MUX];
  assign a_dlpm    = ctrl_a_q[DATA_LINK_PIN_MODE];
  assign a_func    = ctrl_a_q[IDLE_REGISTER_FUNCTION];

  logic line_clk_d1_q, pclk_d1_q;
  logic line_upd, pclk_smp;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_clk_d1_q <= 1'b0;
      pclk_d1_q     <= 1'b0;
    end else begin
      line_clk_d1_q <= line_clk_s;
      pclk_d1_q     <= pclk_s;
    end
  end

  // Update edge: rising at 0, falling at 1
  assign line_upd = a_lpol ? (line_clk_d1_q & ~line_clk_s)
                           : (~line_clk_d1_q & line_clk_s);
  // Sample edge: falling at 0, rising at 1
  assign pclk_smp = a_ppol ? (~pclk_d1_q & pclk_s)
                           : (pclk_d1_q & ~pclk_s);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      line_nrz_data_out   <= 1'b0;
      line_frame_sync_out <= 1'b0;
    end else if (a_alarm) begin
      line_nrz_data_out   <= NRZ_ALARM_LEVEL;
      line_frame_sync_out <= SYNC_ALARM_LEVEL;
    end else if (line_upd) begin
      line_nrz_data_out   <= nrz_s;
      line_frame_sync_out <= sync_s;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pattern_data_sampled <= 1'b0;
    end else if (pclk_smp) begin
      pattern_data_sampled <= pdi_s;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      framer_a_tx_out        <= 1'b0;
      line_interface_tx_data <= 1'b0;
      framer_a_line_rx_data  <= 1'b0;
      shared_rx_clock_a      <= 1'b0;
      shared_rx_data_a       <= 1'b0;
    end else begin
      framer_a_tx_out <= a_test ? tpa_s : atx_s;
      // Disconnected paths idle low
      line_interface_tx_data <=
        a_liu_off ? 1'b0 : (a_test ? tpa_s : atx_s);
      framer_a_line_rx_data  <= a_liu_off ? 1'b0 : lrx_s;
      shared_rx_clock_a <= a_dlpm ? rlclk_a_s : rchclk_a_s;
      shared_rx_data_a  <= a_dlpm ? rlink_a_s : rchblk_a_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Framer B
  logic b_rpol, b_tpol, b_test, b_ff_off, b_dlpm, b_func;
  assign b_rpol   = ctrl_b_q[B_RX_CLOCK_IN_POLARITY];
  assign b_tpol   = ctrl_b_q[B_TX_CLOCK_OUT_POLARITY];
  assign b_test   = ctrl_b_q[B_TEST_MUX_ENABLE];
  assign b_ff_off = ctrl_b_q[B_FRAMER_TO_FRAMER_MUX];
  assign b_dlpm   = ctrl_b_q[DATA_LINK_PIN_MODE];
  assign b_func   = ctrl_b_q[IDLE_REGISTER_FUNCTION];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      framer_b_rx_clock     <= 1'b0;
      framer_b_tx_clock_out <= 1'b0;
      framer_b_tx_out       <= 1'b0;
      framer_b_line_data    <= 1'b0;
      shared_rx_clock_b     <= 1'b0;
      shared_rx_data_b      <= 1'b0;
    end else begin
      framer_b_rx_clock     <= bclk_s ^ b_rpol;
      framer_b_tx_clock_out <= btxclk_s ^ b_tpol;
      framer_b_tx_out       <= b_test ? tpb_s : btx_s;
      framer_b_line_data    <= b_ff_off ? 1'b0 : atx_s;
      shared_rx_clock_b <= b_dlpm ? rlclk_b_s : rchclk_b_s;
      shared_rx_data_b  <= b_dlpm ? rlink_b_s : rchblk_b_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Transmit channel substitution
  logic [7:0] sel_a, sel_b;

  channel_select #(.CHANNELS(CHANNELS), .IDLE_CODE(IDLE_CODE)) u_sel_a (
    .idle_register_function  (a_func),
    .transmit_idle_registers (transmit_idle_registers_a),
    .channel_index           (channel_index),
    .tx_word                 (tx_word_a),
    .rx_word                 (framer_a_rx_serial_data),
    .out_word                (sel_a)
  );

  channel_select #(.CHANNELS(CHANNELS), .IDLE_CODE(IDLE_CODE)) u_sel_b (
    .idle_register_function  (b_func),
    .transmit_idle_registers (transmit_idle_registers_b),
    .channel_index           (channel_index),
    .tx_word                 (tx_word_b),
    .rx_word                 (framer_b_rx_serial_data),
    .out_word                (sel_b)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_word_out_a <= '0;
      tx_word_out_b <= '0;
    end else begin
      tx_word_out_a <= sel_a;
      tx_word_out_b <= sel_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_alarm_set;
    a_alarm;
  endsequence
  AST_ALARM_HOLD: assert property (
    s_alarm_set |=> (line_nrz_data_out && !line_frame_sync_out))
    else $error("alarm force not held on line outputs");
  AST_UNASSIGNED_ZERO: assert property (
    ((ctrl_a_q & ~A_WRITE_MASK) == 8'h00) &&
    ((ctrl_b_q & ~B_WRITE_MASK) == 8'h00))
    else $error("unassigned bit stored");
  AST_LIU_OFF: assert property (
    a_liu_off && $past(a_liu_off) |-> !framer_a_line_rx_data)
    else $error("line interface not disconnected");
  AST_FF_OFF: assert property (
    b_ff_off && $past(b_ff_off) |-> !framer_b_line_data)
    else $error("framer A not disconnected from B");
  AST_B_RX_POL: assert property (
    1'b1 |=> framer_b_rx_clock == ($past(bclk_s) ^ $past(b_rpol)))
    else $error("framer B receive clock polarity wrong");
  AST_TEST_MUX_A: assert property (
    1'b1 |=> framer_a_tx_out == ($past(a_test) ? $past(tpa_s) : $past(atx_s)))
    else $error("framer A test mux selection wrong");
  AST_PIN_MODE_A: assert property (
    a_dlpm |=> shared_rx_clock_a == $past(rlclk_a_s))
    else $error("link clock not routed in link mode");
  AST_LINE_EDGE: assert property (
    !a_alarm && !line_upd |=> $stable(line_nrz_data_out))
    else $error("line output changed off its update edge");
  AST_SAMPLE_EDGE: assert property (
    pclk_smp |=> pattern_data_sampled == $past(pdi_s))
    else $error("pattern data not sampled on edge");
  AST_IDLE_CODE: assert property (
    !a_func && channel_index < CHANNELS &&
    transmit_idle_registers_a[channel_index] |=> tx_word_out_a == IDLE_CODE)
    else $error("idle code not inserted");
endmodule

/* hw/path_ctrl_pkg.sv */
// Register map, field positions and shared constants of the path control bank
package path_ctrl_pkg;

  localparam int          ADDR_W = 8;
  localparam int          DATA_W = 8;

  // Register byte addresses on the parallel control port
  localparam logic [7:0]  FRAMER_A_PATH_CONTROL_ADDR = 8'h11;
  localparam logic [7:0]  FRAMER_B_PATH_CONTROL_ADDR = 8'hb1;

  // Framer A register fields
  localparam int          A_LINE_CLOCK_POLARITY    = 7;
  localparam int          A_PATTERN_CLOCK_POLARITY = 6;
  localparam int          A_TEST_MUX_ENABLE        = 5;
  localparam int          A_NRZ_ALARM_FORCE        = 4;
  localparam int          A_LINE_TO_FRAMER_A_MUX   = 2;

  // Framer B register fields
  localparam int          B_RX_CLOCK_IN_POLARITY   = 7;
  localparam int          B_TX_CLOCK_OUT_POLARITY  = 6;
  localparam int          B_TEST_MUX_ENABLE        = 5;
  localparam int          B_FRAMER_TO_FRAMER_MUX   = 2;

  // Fields common to both registers
  localparam int          DATA_LINK_PIN_MODE       = 1;
  localparam int          IDLE_REGISTER_FUNCTION   = 0;

  // Implemented bits; unassigned ones read back as zero
  localparam logic [7:0]  A_WRITE_MASK = 8'hf7;
  localparam logic [7:0]  B_WRITE_MASK = 8'he7;
  localparam logic [7:0]  RESET_VALUE  = 8'h00;

  // Values carried on the NRZ and frame sync outputs while the alarm is forced
  localparam logic        NRZ_ALARM_LEVEL  = 1'b1;
  localparam logic        SYNC_ALARM_LEVEL = 1'b0;

  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ  = 3'b100
  } bus_state_t;

endpackage

/* hw/pin_sync.sv */
// Two-flop synchroniser for a group of asynchronous pin levels
module pin_sync
  import path_ctrl_pkg::*;
#(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  initial begin
    if (WIDTH < 1) $error("pin_sync width must be positive");
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* tb/dual_framer_path_control_test.sv */
// Self-checking bench for the path control registers and routing
module dual_framer_path_control_test
  import path_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int         CH   = 24;
  localparam logic [7:0] IDLE = 8'h5a;
  localparam logic [7:0] RA   = FRAMER_A_PATH_CONTROL_ADDR;
  localparam logic [7:0] RB   = FRAMER_B_PATH_CONTROL_ADDR;

  logic              sys_clk = 1'b0;
  logic              rst     = 1'b1;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic              wr_en, rd_en, rd_valid;
  logic [19:0]       p       = 20'h00000;
  logic [CH-1:0]     flags_a = 24'h000000;
  logic [CH-1:0]     flags_b = 24'h000000;
  logic [4:0]        chan    = 5'h00;
  logic [7:0]        txa     = 8'h00;
  logic [7:0]        txb     = 8'h00;
  logic [7:0]        rxa     = 8'h00;
  logic [7:0]        rxb     = 8'h00;
  logic [7:0]        outa, outb;
  logic              nrz, fsync, li_tx, a_rx, a_tx, psamp, sca, sda;
  logic              b_rxc, b_txc, b_line, b_tx, scb, sdb;
  logic [31:0]       seed    = 32'he0cd;
  int                miscompares = 0;
  int                checks      = 0;

  always #2 sys_clk = ~sys_clk;

  host_port host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rd_valid(rd_valid));

  dual_framer_path_control #(.CHANNELS(CH), .IDLE_CODE(IDLE)) DUT (
    .sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rd_valid(rd_valid),
    .line_side_clock(p[0]), .pattern_clock(p[1]),
    .framer_a_nrz_in(p[2]), .framer_a_sync_in(p[3]),
    .line_rx_data(p[4]), .framer_a_tx_data(p[5]),
    .test_pattern_a(p[6]), .pattern_data_in(p[7]),
    .line_nrz_data_out(nrz), .line_frame_sync_out(fsync),
    .line_interface_tx_data(li_tx), .framer_a_line_rx_data(a_rx),
    .framer_a_tx_out(a_tx), .pattern_data_sampled(psamp),
    .rx_channel_clock_a(p[8]), .rx_channel_block_a(p[9]),
    .rx_link_clock_a(p[10]), .rx_link_data_a(p[11]),
    .shared_rx_clock_a(sca), .shared_rx_data_a(sda),
    .framer_b_rx_clock_in(p[12]), .framer_b_tx_clock(p[13]),
    .framer_b_tx_data(p[14]), .test_pattern_b(p[15]),
    .rx_channel_clock_b(p[16]), .rx_channel_block_b(p[17]),
    .rx_link_clock_b(p[18]), .rx_link_data_b(p[19]),
    .framer_b_rx_clock(b_rxc), .framer_b_tx_clock_out(b_txc),
    .framer_b_line_data(b_line), .framer_b_tx_out(b_tx),
    .shared_rx_clock_b(scb), .shared_rx_data_b(sdb),
    .transmit_idle_registers_a(flags_a), .transmit_idle_registers_b(flags_b),
    .channel_index(chan), .tx_word_a(txa), .tx_word_b(txb),
    .framer_a_rx_serial_data(rxa), .framer_b_rx_serial_data(rxb),
    .tx_word_out_a(outa), .tx_word_out_b(outb));

  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] exp_word(input logic fn,
      input logic [CH-1:0] flags, input logic [4:0] idx,
      input logic [7:0] tx, input logic [7:0] rx);
    if (idx < CH && flags[idx]) return fn ? rx : IDLE;
    return tx;
  endfunction

  // Covers the two-flop pin latency plus the output register
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask

  task automatic chk_routes(input logic [7:0] ra, input logic [7:0] rb);
    logic       ta;
    logic [7:0] ea, eb;
    ta = ra[A_TEST_MUX_ENABLE] ? p[6] : p[5];
    ea = exp_word(ra[IDLE_REGISTER_FUNCTION], flags_a, chan, txa, rxa);
    eb = exp_word(rb[IDLE_REGISTER_FUNCTION], flags_b, chan, txb, rxb);
    check(a_tx, ta);
    check(b_tx, rb[B_TEST_MUX_ENABLE] ? p[15] : p[14]);
    check(a_rx, ra[A_LINE_TO_FRAMER_A_MUX] ? 1'h0 : p[4]);
    check(li_tx, ra[A_LINE_TO_FRAMER_A_MUX] ? 1'h0 : ta);
    check(b_line, rb[B_FRAMER_TO_FRAMER_MUX] ? 1'h0 : p[5]);
    check(sca, ra[DATA_LINK_PIN_MODE] ? p[10] : p[8]);
    check(sda, ra[DATA_LINK_PIN_MODE] ? p[11] : p[9]);
    check(scb, rb[DATA_LINK_PIN_MODE] ? p[18] : p[16]);
    check(sdb, rb[DATA_LINK_PIN_MODE] ? p[19] : p[17]);
    check(b_rxc, p[12] ^ rb[B_RX_CLOCK_IN_POLARITY]);
    check(b_txc, p[13] ^ rb[B_TX_CLOCK_OUT_POLARITY]);
    if (ra[A_NRZ_ALARM_FORCE]) begin
      check(nrz, 1'h1);
      check(fsync, 1'h0);
    end
    check(outa, ea);
    check(outb, eb);
  endtask

  task automatic complete_run();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end

  initial begin : main
    logic [7:0] ra, rb, d;
    int         i;
    repeat (3) @(negedge sys_clk);
    rst = 1'b0;
    host.read_reg(RA, d);
    check(d, 8'h00);
    host.read_reg(RB, d);
    check(d, 8'h00);
    host.write_reg(RA, 8'hff, 1'b1);
    host.write_reg(RB, 8'hff, 1'b1);
    host.write_reg(8'h12, 8'hff, 1'b1);
    host.read_reg(8'h12, d);
    check(d, 8'h00);
    host.read_reg(RA, d);
    check(d, 8'hf7);
    host.read_reg(RB, d);
    check(d, 8'he7);
    settle();
    chk_routes(8'hf7, 8'he7);
    $display("test unassigned bits done");
    for (i = 0; i < 30; i++) begin
      seed = lfsr(seed);
      ra = seed[7:0] & A_WRITE_MASK;
      rb = seed[15:8] & B_WRITE_MASK;
      host.write_reg(RA, seed[7:0], 1'b0);
      host.write_reg(RB, seed[15:8], 1'b0);
      seed = lfsr(seed);
      p = seed[19:0];
      seed = lfsr(seed);
      flags_a = seed[23:0];
      chan = seed[28:24];
      seed = lfsr(seed);
      {rxb, rxa, txb, txa} = seed;
      seed = lfsr(seed);
      flags_b = seed[23:0];
      settle();
      chk_routes(ra, rb);
      host.read_reg(RA, d);
      check(d, ra);
      host.read_reg(RB, d);
      check(d, rb);
    end
    $display("test random routing done");
    for (i = 0; i < 2; i++) begin
      host.write_reg(RA, {i[0], i[0], 6'h00}, 1'b0);
      seed = lfsr(seed);
      p[1:0] = 2'h0;
      {p[7], p[3], p[2]} = {3{seed[0]}};
      settle();
      p[1:0] = 2'h3;
      settle();
      {p[7], p[3], p[2]} = {3{~seed[0]}};
      settle();
      p[1:0] = 2'h0;
      settle();
      check(nrz, seed[0] != i[0]);
      check(fsync, seed[0] != i[0]);
      check(psamp, seed[0] == i[0]);
    end
    $display("test clock polarity done");
    complete_run();
  end
endmodule

/* tb/host_port.sv */
// Host processor model on the parallel control port
module host_port
  import path_ctrl_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Control port
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] wdata,
  output logic                   wr_en,
  output logic                   rd_en,
  input  wire logic [DATA_W-1:0] rdata,
  input  wire logic              rd_valid
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] keep_mask(input logic [7:0] a);
    if (a == FRAMER_A_PATH_CONTROL_ADDR) return A_WRITE_MASK;
    if (a == FRAMER_B_PATH_CONTROL_ADDR) return B_WRITE_MASK;
    return 8'hff;
  endfunction

  // Raw writes leave unassigned bits set, to check that the register drops them
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d,
                           input bit raw);
    @(negedge sys_clk);
    addr  = a;
    wdata = raw ? d : (d & keep_mask(a));
    wr_en = 1'b1;
    @(negedge sys_clk);
    wr_en = 1'b0;
    addr  = ~addr;
    wdata = ~wdata;
  endtask

  // Released address is inverted so a stale value never looks valid
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(negedge sys_clk);
    addr  = a;
    rd_en = 1'b1;
    @(negedge sys_clk);
    rd_en = 1'b0;
    addr  = ~addr;
    for (n = 0; n < 4 && rd_valid !== 1'b1; n++) @(negedge sys_clk);
    d = (rd_valid === 1'b1) ? rdata : 8'hxx;
  endtask
endmodule
